// *** core/pc_pkg.sv ***
// Constants and helpers of the configuration header block
package pc_pkg;
   // --------------------------------
   // Byte offsets of the header
   // --------------------------------
   localparam logic [7:0] OFS_REVISION = 8'h08;
   localparam logic [7:0] OFS_PROG_IF = 8'h09;
   localparam logic [7:0] OFS_SUB_CLASS = 8'h0a;
   localparam logic [7:0] OFS_BASE_CLASS = 8'h0b;
   localparam logic [7:0] OFS_CACHE_LINE = 8'h0c;
   localparam logic [7:0] OFS_LATENCY = 8'h0d;
   localparam logic [7:0] OFS_IO_BASE = 8'h10;
   localparam logic [7:0] OFS_MEM_BASE = 8'h14;
   localparam logic [7:0] OFS_ROM_BASE = 8'h30;
   localparam logic [7:0] OFS_EEPROM = 8'h34;
   localparam logic [7:0] OFS_IRQ_LINE = 8'h3c;
   // --------------------------------
   // Fixed values
   // --------------------------------
   localparam logic [7:0] BASE_CLASS = 8'h02;
   localparam logic [7:0] PROG_IF = 8'h00;
   localparam logic [7:0] SUB_CLASS_FALLBACK = 8'h80;
   localparam logic [3:0] IO_BAR_LOW = 4'h1;
   localparam logic [3:0] MEM_BAR_LOW = 4'h0;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [15:0] ZERO_LINE_BYTES = 16'h0010;
   localparam int MULTI_LINE_SHIFT = 2;
   // --------------------------------
   // EEPROM register fields and ROM base enable bit
   // --------------------------------
   localparam int EE_PRESENT = 7;
   localparam int EE_DATA_DRIVE = 5;
   localparam int EE_DATA = 4;
   localparam int EE_CLOCK_DRIVE = 1;
   localparam int EE_CLOCK = 0;
   localparam int ROM_ENABLE_BIT = 0;

   // Byte enable merge of a write
   function automatic logic [31:0] pc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// *** core/pc_rdcmd_if.sv ***
// Carrier between header logic and read command chooser
interface pc_rdcmd_if;
   logic [7:0] line_size; // Cache line size in dwords
   logic [15:0] xfer_len; // Read length in bytes
   logic use_multiple; // High picks read multiple
   modport owner (output line_size, output xfer_len, input use_multiple);
   modport chooser (input line_size, input xfer_len, output use_multiple);
endinterface

// *** core/pc_rdcmd.sv ***
// Picks the bus master read command from cache line size
module pc_rdcmd (
   pc_rdcmd_if.chooser bus
);
   logic [7:0] pow2; // Line size rounded down
   logic [15:0] line_bytes; // Line size in bytes
   logic [15:0] thresh; // Four lines in bytes

   // Line rounding and comparison
   always_comb
   begin
      pow2 = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         if (bus.line_size[i])
         begin
            pow2 = 8'h01 << i;
         end
      end
      if (pow2 == 8'h00)
      begin
         line_bytes = pc_pkg::ZERO_LINE_BYTES;
      end
      else
      begin
         line_bytes = {6'h00, pow2, 2'b00};
      end
      thresh = line_bytes << pc_pkg::MULTI_LINE_SHIFT;
      bus.use_multiple = (bus.xfer_len >= thresh);
   end
endmodule

// *** core/pc_pin_sync.sv ***
// Two flip-flop synchroniser for the EEPROM pin levels
module pc_pin_sync (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] pin_raw,
   output logic [1:0] pin_sync
);
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
   } pc_sync_t;
   pc_sync_t st_ff; // Synchroniser stages
   pc_sync_t nxt_st; // Next stages

   // Shift the stages
   always_comb
   begin
      nxt_st.meta = pin_raw;
      nxt_st.sync = st_ff.meta;
   end

   // Register the stages
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign pin_sync = st_ff.sync;
endmodule

// *** core/pc_cfg_header.sv ***
// Configuration header registers and EEPROM pin port
module pc_cfg_header #(
   parameter logic [7:0] REV_FALLBACK = 8'h01 // Arbitrary built-in revision
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire logic autocfg_done,
   input wire logic autocfg_ok,
   input wire logic [7:0] autocfg_subclass,
   input wire logic [7:0] autocfg_revision,
   input wire logic eeprom_present,
   input wire logic mem_space_en,
   input wire logic soft_reset,
   input wire logic direct_io_window_data_wr,
   input wire logic net_serial_clock_o,
   input wire logic net_serial_clock_oe,
   input wire logic net_serial_data_o,
   input wire logic net_serial_data_oe,
   input wire logic eeprom_clock_pin_i,
   output logic eeprom_clock_pin_o,
   output logic eeprom_clock_pin_oe,
   input wire logic eeprom_data_pin_i,
   output logic eeprom_data_pin_o,
   output logic eeprom_data_pin_oe,
   output logic eeprom_clock_level,
   output logic eeprom_data_level,
   input wire logic [15:0] dma_read_len,
   output logic use_read_multiple,
   output logic rom_access_enable,
   output logic [7:0] latency_timer_value
);
   // --------------------------------
   // State
   // --------------------------------
   typedef struct packed {
      logic [7:0] revision; // Revision byte
      logic [7:0] subclass; // Subclass byte
      logic [7:0] cache_line; // Cache line size
      logic [7:0] latency; // Latency timer
      logic [27:0] io_base; // I/O base upper bits
      logic [27:0] mem_base; // Memory base upper bits
      logic [15:0] rom_base; // ROM base upper bits
      logic rom_decode_enable; // ROM decode enable
      logic data_drive; // Data pin drive
      logic data_bit; // Data value
      logic clock_drive; // Clock pin drive
      logic clock_bit; // Clock value
      logic cfg_owns; // Config register owns pins
      logic [7:0] irq_line; // Interrupt line byte
      logic [31:0] rdata; // Read answer
      logic ack; // Answer strobe
      logic clk_o; // Clock pin value
      logic clk_oe; // Clock pin enable
      logic dat_o; // Data pin value
      logic dat_oe; // Data pin enable
      logic rom_access; // ROM decode allowed
      logic use_multiple; // Read multiple chosen
   } pc_state_t;

   localparam pc_state_t RESET_STATE = '{
      revision: REV_FALLBACK,
      subclass: pc_pkg::SUB_CLASS_FALLBACK,
      cache_line: pc_pkg::RESET_ZERO,
      latency: pc_pkg::RESET_ZERO,
      cfg_owns: 1'b1,
      default: '0
   };

   pc_state_t st_ff; // Registered state
   pc_state_t nxt_st; // Next state
   logic [1:0] pin_sync; // Synced clock and data pins
   logic wr; // Write access
   logic rd; // Read access
   logic [5:0] dw; // Accessed dword
   logic [31:0] rd_val; // Read mux value
   logic [31:0] m; // Merged write data
   logic [7:0] ee_byte; // EEPROM register view

   pc_rdcmd_if rdc ();

   // --------------------------------
   // Helpers
   // --------------------------------
   pc_pin_sync u_sync (
      .clock(clock),
      .reset_n(reset_n),
      .pin_raw({eeprom_clock_pin_i, eeprom_data_pin_i}),
      .pin_sync(pin_sync)
   );

   pc_rdcmd u_rdcmd (
      .bus(rdc)
   );

   assign rdc.line_size = st_ff.cache_line;
   assign rdc.xfer_len = dma_read_len;

   // --------------------------------
   // Next state
   // --------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      wr = cfg_req && cfg_we;
      rd = cfg_req && !cfg_we;
      dw = cfg_addr[7:2];
      m = '0;
      // EEPROM register view
      ee_byte = '0;
      ee_byte[pc_pkg::EE_PRESENT] = eeprom_present;
      ee_byte[pc_pkg::EE_DATA_DRIVE] = st_ff.data_drive;
      ee_byte[pc_pkg::EE_DATA] = st_ff.data_drive ? st_ff.data_bit : pin_sync[0];
      ee_byte[pc_pkg::EE_CLOCK_DRIVE] = st_ff.clock_drive;
      ee_byte[pc_pkg::EE_CLOCK] = st_ff.clock_drive ? st_ff.clock_bit : pin_sync[1];

      // Read mux, unmapped reads zero
      rd_val = '0;
      case (dw)
         pc_pkg::OFS_REVISION[7:2]:
         begin
            rd_val = {pc_pkg::BASE_CLASS, st_ff.subclass, pc_pkg::PROG_IF, st_ff.revision};
         end
         pc_pkg::OFS_CACHE_LINE[7:2]:
         begin
            rd_val = {16'h0000, st_ff.latency, st_ff.cache_line};
         end
         pc_pkg::OFS_IO_BASE[7:2]:
         begin
            rd_val = {st_ff.io_base, pc_pkg::IO_BAR_LOW};
         end
         pc_pkg::OFS_MEM_BASE[7:2]:
         begin
            rd_val = {st_ff.mem_base, pc_pkg::MEM_BAR_LOW};
         end
         pc_pkg::OFS_ROM_BASE[7:2]:
         begin
            rd_val = {st_ff.rom_base, 15'h0000, st_ff.rom_decode_enable};
         end
         pc_pkg::OFS_EEPROM[7:2]:
         begin
            rd_val = {24'h000000, ee_byte};
         end
         pc_pkg::OFS_IRQ_LINE[7:2]:
         begin
            rd_val = {24'h000000, st_ff.irq_line};
         end
         default:
         begin
            rd_val = '0;
         end
      endcase

      // Answer one cycle after request
      nxt_st.ack = cfg_req;
      if (rd)
      begin
         nxt_st.rdata = rd_val;
      end
      else if (cfg_req)
      begin
         nxt_st.rdata = '0;
      end

      // Writes
      if (wr)
      begin
         m = pc_pkg::pc_merge(rd_val, cfg_wdata, cfg_be);
         case (dw)
            pc_pkg::OFS_CACHE_LINE[7:2]:
            begin
               nxt_st.cache_line = m[7:0];
               nxt_st.latency = m[15:8];
            end
            pc_pkg::OFS_IO_BASE[7:2]:
            begin
               nxt_st.io_base = m[31:4];
            end
            pc_pkg::OFS_MEM_BASE[7:2]:
            begin
               nxt_st.mem_base = m[31:4];
            end
            pc_pkg::OFS_ROM_BASE[7:2]:
            begin
               nxt_st.rom_base = m[31:16];
               nxt_st.rom_decode_enable = m[pc_pkg::ROM_ENABLE_BIT];
            end
            pc_pkg::OFS_EEPROM[7:2]:
            begin
               if (cfg_be[0])
               begin
                  nxt_st.data_drive = cfg_wdata[pc_pkg::EE_DATA_DRIVE];
                  nxt_st.data_bit = cfg_wdata[pc_pkg::EE_DATA];
                  nxt_st.clock_drive = cfg_wdata[pc_pkg::EE_CLOCK_DRIVE];
                  nxt_st.clock_bit = cfg_wdata[pc_pkg::EE_CLOCK];
               end
            end
            pc_pkg::OFS_IRQ_LINE[7:2]:
            begin
               nxt_st.irq_line = m[7:0];
            end
            default:
            begin
               nxt_st.irq_line = st_ff.irq_line;
            end
         endcase
      end

      if (soft_reset)
      begin
         nxt_st.cfg_owns = 1'b1;
      end
      else if (wr && dw == pc_pkg::OFS_EEPROM[7:2])
      begin
         nxt_st.cfg_owns = 1'b1;
      end
      else if (direct_io_window_data_wr)
      begin
         nxt_st.cfg_owns = 1'b0;
      end

      if (autocfg_done)
      begin
         nxt_st.subclass = autocfg_ok ? autocfg_subclass : pc_pkg::SUB_CLASS_FALLBACK;
         nxt_st.revision = autocfg_ok ? autocfg_revision : REV_FALLBACK;
      end

      if (st_ff.cfg_owns)
      begin
         nxt_st.clk_o = st_ff.clock_bit;
         nxt_st.clk_oe = st_ff.clock_drive;
         nxt_st.dat_o = st_ff.data_bit;
         nxt_st.dat_oe = st_ff.data_drive;
      end
      else
      begin
         nxt_st.clk_o = net_serial_clock_o;
         nxt_st.clk_oe = net_serial_clock_oe;
         nxt_st.dat_o = net_serial_data_o;
         nxt_st.dat_oe = net_serial_data_oe;
      end

      nxt_st.rom_access = st_ff.rom_decode_enable && mem_space_en;
      nxt_st.use_multiple = rdc.use_multiple;
   end

   // --------------------------------
   // State register
   // --------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_ff <= RESET_STATE;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign cfg_rdata = st_ff.rdata;
   assign cfg_ack = st_ff.ack;
   assign eeprom_clock_pin_o = st_ff.clk_o;
   assign eeprom_clock_pin_oe = st_ff.clk_oe;
   assign eeprom_data_pin_o = st_ff.dat_o;
   assign eeprom_data_pin_oe = st_ff.dat_oe;
   assign eeprom_clock_level = pin_sync[1];
   assign eeprom_data_level = pin_sync[0];
   assign use_read_multiple = st_ff.use_multiple;
   assign rom_access_enable = st_ff.rom_access;
   assign latency_timer_value = st_ff.latency;

   // --------------------------------
   // Assertions
   // --------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence s_rd(logic [7:0] a);
      cfg_req && !cfg_we && cfg_addr[7:2] == a[7:2];
   endsequence

   property p_class;
      s_rd(pc_pkg::OFS_BASE_CLASS) |=> cfg_ack && cfg_rdata[31:24] == pc_pkg::BASE_CLASS;
   endproperty
   a_class: assert property (p_class) else $error("base class wrong");

   property p_progif;
      s_rd(pc_pkg::OFS_PROG_IF) |=> cfg_rdata[15:8] == pc_pkg::PROG_IF;
   endproperty
   a_progif: assert property (p_progif) else $error("prog if not zero");

   property p_sub_fallback;
      autocfg_done && !autocfg_ok |=> st_ff.subclass == pc_pkg::SUB_CLASS_FALLBACK;
   endproperty
   a_sub_fallback: assert property (p_sub_fallback) else $error("subclass fallback missed");

   property p_rev_load;
      autocfg_done && autocfg_ok |=> st_ff.revision == $past(autocfg_revision);
   endproperty
   a_rev_load: assert property (p_rev_load) else $error("revision not loaded");

   property p_io_low;
      s_rd(pc_pkg::OFS_IO_BASE) |=> cfg_rdata[3:0] == pc_pkg::IO_BAR_LOW;
   endproperty
   a_io_low: assert property (p_io_low) else $error("io base low bits wrong");

   property p_mem_low;
      s_rd(pc_pkg::OFS_MEM_BASE) |=> cfg_rdata[3:0] == pc_pkg::MEM_BAR_LOW;
   endproperty
   a_mem_low: assert property (p_mem_low) else $error("mem base low bits wrong");

   property p_rom_gate;
      ##1 rom_access_enable == ($past(st_ff.rom_decode_enable) && $past(mem_space_en));
   endproperty
   a_rom_gate: assert property (p_rom_gate) else $error("rom gate wrong");

   sequence s_dio_take;
      direct_io_window_data_wr && !soft_reset && !(wr && dw == pc_pkg::OFS_EEPROM[7:2]) ##1 1'b1;
   endsequence

   property p_dio_owns;
      s_dio_take |=> eeprom_clock_pin_oe == $past(net_serial_clock_oe);
   endproperty
   a_dio_owns: assert property (p_dio_owns) else $error("pins not handed over");

   property p_nv_reserved;
      s_rd(pc_pkg::OFS_EEPROM) |=> cfg_rdata[6] == 1'b0 && cfg_rdata[3:2] == 2'b00;
   endproperty
   a_nv_reserved: assert property (p_nv_reserved) else $error("reserved bits set");
endmodule

// *** verification/pc_host_model.sv ***
// Host bridge model that issues configuration cycles
module pc_host_model (
   input wire logic clock,
   output logic cfg_req,
   output logic cfg_we,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial
   begin
      cfg_req = 1'b0;
      cfg_we = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
   end

   // bit-bang via config
   // One request pulse, answer taken at the edge where ack stands
   task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                         output logic [31:0] rd, output logic ak);
      @(posedge clock);
      cfg_req <= 1'b1;
      cfg_we <= we;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= wd;
      @(posedge clock);
      cfg_req <= 1'b0;
      cfg_wdata <= ~wd;
      // Sample ack and data at the edge that sees them high
      @(posedge clock);
      rd = cfg_rdata;
      ak = cfg_ack;
   endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench of the configuration header block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // Signals and model state
   // ------------------------------
   localparam logic [7:0] REV = 8'h5a; // Arbitrary built-in revision
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic cfg_req, cfg_we, cfg_ack;
   logic [7:0] cfg_addr, lat;
   logic [3:0] cfg_be;
   logic [31:0] cfg_rdata, cfg_wdata;
   logic [2:0] pl = 3'h0; // Pulses: DIO write, soft reset, autoconfig done
   logic ac_ok = 1'b0, present = 1'b0, mem_en = 1'b0;
   logic [7:0] ac_sub = 8'h00, ac_rev = 8'h00;
   logic [3:0] ns = 4'h0; // Network drive: clock o, clock oe, data o, data oe
   logic ext_ck = 1'b1, ext_dt = 1'b1; // Far side level, pulled up
   logic ck_o, ck_oe, dt_o, dt_oe, ck_lvl, dt_lvl, use_mult, rom_en;
   logic [15:0] len = 16'h0000;
   logic [15:0] seed = 16'hfacd;
   int failures = 0;
   int checked = 0;
   logic [31:0] mdl [logic [7:0]]; // Expected dword per offset
   logic [31:0] wmask [logic [7:0]]; // Writable bits per offset
   logic [7:0] offs [8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h30, 8'h34, 8'h3c, 8'h24};
   logic [7:0] cls_tab [8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h21, 8'hff};
   wire ck_pin = ck_oe ? ck_o : ext_ck; // Resolved clock pin
   wire dt_pin = dt_oe ? dt_o : ext_dt; // Resolved data pin

   // 40 MHz clock
   always #12.5 clock = ~clock;

   pc_host_model u_host (.clock(clock), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

   pc_cfg_header #(.REV_FALLBACK(REV)) u_dut (.clock(clock), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .autocfg_done(pl[0]), .autocfg_ok(ac_ok), .autocfg_subclass(ac_sub), .autocfg_revision(ac_rev),
      .eeprom_present(present), .mem_space_en(mem_en), .soft_reset(pl[1]), .direct_io_window_data_wr(pl[2]),
      .net_serial_clock_o(ns[3]), .net_serial_clock_oe(ns[2]), .net_serial_data_o(ns[1]), .net_serial_data_oe(ns[0]),
      .eeprom_clock_pin_i(ck_pin), .eeprom_clock_pin_o(ck_o), .eeprom_clock_pin_oe(ck_oe),
      .eeprom_data_pin_i(dt_pin), .eeprom_data_pin_o(dt_o), .eeprom_data_pin_oe(dt_oe),
      .eeprom_clock_level(ck_lvl), .eeprom_data_level(dt_lvl), .dma_read_len(len), .use_read_multiple(use_mult),
      .rom_access_enable(rom_en), .latency_timer_value(lat));

   // ------------------------------
   // Helpers
   // ------------------------------
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Next LFSR word
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Two LFSR steps make one random dword
   task automatic rnd(output logic [31:0] r);
      seed = lfsr(seed);
      r[31:16] = seed;
      seed = lfsr(seed);
      r[15:0] = seed;
   endtask

   // Pulse one of the strobe inputs for a cycle
   task automatic pulse(input int i);
      @(posedge clock);
      pl[i] <= 1'b1;
      @(posedge clock);
      pl <= 3'h0;
   endtask

   // Let pin flops and synchroniser settle
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask

   // Pin drive as one word
   function automatic logic [31:0] pins();
      return {28'h0, ck_o, ck_oe, dt_o, dt_oe};
   endfunction

   // One config cycle, model merges writable bits
   task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rd);
      logic ak;
      logic [31:0] m;
      u_host.access(we, a, be, wd, rd, ak);
      chk("ack", {31'h0, ak}, 32'h1);
      if (we && wmask.exists(a))
      begin
         for (int i = 0; i < 4; i++)
            m[i*8 +: 8] = {8{be[i]}};
         m = m & wmask[a];
         mdl[a] = (mdl[a] & ~m) | (wd & m);
      end
   endtask

   // EEPROM port readback: undriven bits follow the pins
   function automatic logic [31:0] ee_exp();
      logic [31:0] v;
      v = mdl[8'h34];
      v[7] = present;
      if (!v[5])
         v[4] = ext_dt;
      if (!v[1])
         v[0] = ext_ck;
      return v;
   endfunction

   // Read every modelled offset and an unmapped one
   task automatic check_all();
      logic [31:0] rd;
      settle();
      foreach (mdl[a])
      begin
         acc(1'b0, a, 4'h0, 32'h0, rd);
         chk("dword", rd, (a == 8'h34) ? ee_exp() : mdl[a]);
      end
      acc(1'b0, 8'h24, 4'h0, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      chk("latency", {24'h0, lat}, {24'h0, mdl[8'h0c][15:8]});
      chk("pin level", {30'h0, ck_lvl, dt_lvl}, {30'h0, ck_pin, dt_pin});
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      logic [31:0] r, w, rd;
      int p, line;
      mdl[8'h08] = {8'h02, 8'h80, 8'h00, REV};
      mdl[8'h0c] = 32'h0;
      mdl[8'h10] = 32'h1;
      mdl[8'h14] = 32'h0;
      mdl[8'h30] = 32'h0;
      mdl[8'h34] = 32'h0;
      wmask[8'h08] = 32'h0;
      wmask[8'h0c] = 32'hffff;
      wmask[8'h10] = 32'hfffffff0;
      wmask[8'h14] = 32'hfffffff0;
      wmask[8'h30] = 32'hffff0001;
      wmask[8'h34] = 32'h33;
      wmask[8'h3c] = 32'hff;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      check_all();
      chk("pin oe", pins() & 32'h5, 32'h0);
      // Autoconfig loads, good and bad checksum
      for (int k = 0; k < 4; k++)
      begin
         rnd(r);
         ac_ok <= k[0];
         present <= r[8];
         ext_ck <= r[9];
         ext_dt <= r[10];
         ac_sub <= r[23:16];
         ac_rev <= r[31:24];
         pulse(0);
         mdl[8'h08][23:0] = k[0] ? {r[23:16], 8'h00, r[31:24]} : {8'h80, 8'h00, REV};
         check_all();
      end
      // Random writes over all offsets
      rnd(r);
      mdl[8'h3c] = 32'h0;
      acc(1'b1, 8'h3c, 4'hf, r, rd);
      for (int k = 0; k < 40; k++)
      begin
         rnd(r);
         rnd(w);
         acc(1'b1, offs[r[2:0]], r[7:4], w, rd);
      end
      check_all();
      // Read command threshold at both sides
      foreach (cls_tab[i])
         for (int d = 0; d < 2; d++)
         begin
            p = 1;
            while (p * 2 <= cls_tab[i])
               p = p * 2;
            line = (cls_tab[i] == 0) ? 16 : p * 4;
            len <= 16'(line * 4 - 1 + d);
            acc(1'b1, 8'h0c, 4'h1, {24'h0, cls_tab[i]}, rd);
            settle();
            chk("read multiple", {31'h0, use_mult}, 32'(d));
         end
      // Pin ownership handover
      acc(1'b1, 8'h34, 4'h1, 32'hff, rd);
      settle();
      chk("pins cfg", pins(), 32'hf);
      ns <= 4'b0110;
      pulse(2);
      settle();
      chk("pins net", pins(), 32'h6);
      acc(1'b1, 8'h34, 4'h1, 32'h00, rd);
      settle();
      chk("pins back", pins() & 32'h5, 32'h0);
      pulse(2);
      pulse(1);
      settle();
      chk("pins soft", pins() & 32'h5, 32'h0);
      // ROM decode gated by memory enable
      for (int k = 0; k < 4; k++)
      begin
         acc(1'b1, 8'h30, 4'h1, {31'h0, k[0]}, rd);
         mem_en <= k[1];
         settle();
         chk("rom enable", {31'h0, rom_en}, {31'h0, k[0] & k[1]});
      end
      check_all();
      tally_and_finish();
   end

   // Watchdog: run needs a few hundred cycles, allow 20000
   initial
   begin
      #500000;
      failures++;
      tally_and_finish();
   end
endmodule
